/* asirq_top.sv */
/*
 Addressed SPI slave with interrupt unit, thermal shutdown and write lock.
 Assumes SPI pins, strap and temperature levels are asynchronous to
 ref_clk; live conditions and channel-two data come from ref_clk logic.
 The serial clock must stay well below a quarter of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module asirq_top
	import asirq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	input wire logic [2:0] addr_strap,
	input wire logic temp_above_limit,
	input wire logic temp_below_release,
	input wire asirq_pkg::asirq_word_t live_cond,
	input wire logic channel_two_filtered_output,
	output logic shared_pin_o,
	output logic shared_pin_oe,
	output logic load_current_en,
	output logic config_transfer
);
	import asirq_pkg::*;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [7:0] sync_q;
	logic sclk_s, cs_n_s, mosi_s, hot_s, cool_s;
	logic [2:0] strap_s;

	// Pins cross into ref_clk through two flops each
	asirq_sync #(.W(8)) u_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.d({sclk, cs_n, mosi, temp_above_limit, temp_below_release,
			addr_strap}),
		.q(sync_q)
	);
	assign {sclk_s, cs_n_s, mosi_s, hot_s, cool_s, strap_s} = sync_q;

	// ----------------------------------------
	// Reset sequencing and thermal state
	// ----------------------------------------
	localparam int BUSY_W = $clog2(`ASIRQ_RST_BUSY_CYC + 1);
	localparam logic [BUSY_W-1:0] BUSY_LAST =
		BUSY_W'(`ASIRQ_RST_BUSY_CYC - 1);
	logic busy_r, busy_nxt;
	logic [BUSY_W-1:0] busy_cnt_r, busy_cnt_nxt;
	logic tsd_r, tsd_nxt;
	logic [2:0] chip_r, chip_nxt;
	logic soft_rst, addr_reload, reset_done;

	// Busy window after power-up or software reset; strap caught at end
	always_comb begin
		busy_nxt = busy_r;
		busy_cnt_nxt = busy_cnt_r;
		chip_nxt = chip_r;
		tsd_nxt = tsd_r;
		reset_done = 1'b0;
		if (soft_rst) begin
			busy_nxt = 1'b1;
			busy_cnt_nxt = '0;
		end else if (busy_r) begin
			if (busy_cnt_r == BUSY_LAST) begin
				busy_nxt = 1'b0;
				reset_done = 1'b1;
				chip_nxt = strap_s;
			end else begin
				busy_cnt_nxt = busy_cnt_r + 1'b1;
			end
		end else if (addr_reload) begin
			chip_nxt = strap_s;
		end
		// Cut on overtemperature, restore only past the hysteresis
		if (hot_s) begin
			tsd_nxt = 1'b1;
		end else if (cool_s) begin
			tsd_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busy_r <= 1'b1;
			busy_cnt_r <= '0;
			tsd_r <= 1'b0;
			chip_r <= 3'h0;
		end else begin
			busy_r <= busy_nxt;
			busy_cnt_r <= busy_cnt_nxt;
			tsd_r <= tsd_nxt;
			chip_r <= chip_nxt;
		end
	end

	assign load_current_en = ~tsd_r;

	// ----------------------------------------
	// SPI engine and register file
	// ----------------------------------------
	asirq_state_t st_r, st_nxt;
	logic sclk_d_r;
	logic [4:0] cnt_r, cnt_nxt;
	asirq_word_t rx_r, rx_nxt;
	asirq_word_t tx_r, tx_nxt;
	asirq_word_t hdr_r, hdr_nxt;
	logic miso_r, miso_nxt;
	logic crc_en_r, crc_en_nxt;
	logic pin_mode_r, pin_mode_nxt;
	asirq_word_t mask_r, mask_nxt;
	asirq_word_t flags_r, flags_nxt;
	logic lock_r, lock_nxt;
	logic xfer_r, xfer_nxt;
	logic crc_load;
	asirq_word_t crc_val, live_val, rd_val, hdr_word, wdata, w1c, set_ev;
	asirq_addr_t rd_addr;
	logic rise, fall, addr_hit, wr_fire;

	// Serial clock edges from the synchronised copy only
	assign rise = sclk_s & ~sclk_d_r;
	assign fall = ~sclk_s & sclk_d_r;
	assign hdr_word = {rx_r[14:0], mosi_s};

	// Live view: conditions as they are, bit 14 busy
	always_comb begin
		live_val = live_cond;
		live_val[`ASIRQ_FLAG_THERMAL_BIT] = tsd_r;
		live_val[`ASIRQ_FLAG_RESET_BIT] = busy_r;
	end

	// Read multiplexer; unmapped offsets return zero
	assign rd_addr = hdr_word[`ASIRQ_HDR_ADDR_MSB:`ASIRQ_HDR_ADDR_LSB];
	always_comb begin
		rd_val = '0;
		unique case (rd_addr)
			`ASIRQ_OFS_DEVICE_CONTROL: begin
				rd_val[`ASIRQ_CTRL_CRC_EN_BIT] = crc_en_r;
				rd_val[`ASIRQ_CTRL_PIN_MODE_BIT] = pin_mode_r;
			end
			`ASIRQ_OFS_INTERRUPT_ENABLE_BITS: rd_val = mask_r;
			`ASIRQ_OFS_LATCHED_EVENT_FLAGS: rd_val = flags_r;
			`ASIRQ_OFS_LIVE_CONDITION_FLAGS: rd_val = live_val;
			`ASIRQ_OFS_CONFIG_WRITE_GUARD: begin
				rd_val[`ASIRQ_LOCK_STATE_BIT] = lock_r;
			end
			default: rd_val = '0;
		endcase
	end

	// CRC taken over the very word that is shifted out
	asirq_crc u_crc (
		.ref_clk(ref_clk),
		.srst(srst),
		.load(crc_load),
		.data(rd_val),
		.crc(crc_val)
	);

	// Header addresses this chip, or a write is broadcast
	assign addr_hit = (hdr_word[`ASIRQ_HDR_CHIP_MSB:`ASIRQ_HDR_CHIP_LSB]
		== chip_r);
	assign wdata = {rx_r[14:0], mosi_s};
	assign wr_fire = (st_r == ASIRQ_WDATA) && rise &&
		(cnt_r == 5'(`ASIRQ_WORD_BITS - 1));

	// Transfer sequencing, bit counting and register writes
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		hdr_nxt = hdr_r;
		miso_nxt = miso_r;
		crc_en_nxt = crc_en_r;
		pin_mode_nxt = pin_mode_r;
		mask_nxt = mask_r;
		lock_nxt = lock_r;
		xfer_nxt = 1'b0;
		crc_load = 1'b0;
		soft_rst = 1'b0;
		addr_reload = 1'b0;
		w1c = '0;
		unique case (st_r)
			ASIRQ_IDLE: begin
				if (!cs_n_s && !busy_r) begin
					st_nxt = ASIRQ_HDR;
					cnt_nxt = '0;
				end
			end
			ASIRQ_HDR: begin
				if (rise) begin
					rx_nxt = hdr_word;
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == 5'(`ASIRQ_WORD_BITS - 1)) begin
						hdr_nxt = hdr_word;
						cnt_nxt = '0;
						if (hdr_word[`ASIRQ_HDR_READ_BIT]) begin
							// One register per read, sent from next fall
							if (addr_hit) begin
								st_nxt = ASIRQ_RDATA;
								tx_nxt = rd_val;
								crc_load = 1'b1;
							end else begin
								st_nxt = ASIRQ_DONE;
							end
						end else if (hdr_word[`ASIRQ_HDR_BCAST_BIT] ||
							addr_hit) begin
							st_nxt = ASIRQ_WDATA;
						end else begin
							st_nxt = ASIRQ_DONE;
						end
					end
				end
			end
			ASIRQ_WDATA: begin
				if (rise) begin
					rx_nxt = wdata;
					cnt_nxt = cnt_r + 5'h01;
				end
				if (wr_fire) begin
					st_nxt = ASIRQ_DONE;
					unique case (hdr_r[`ASIRQ_HDR_ADDR_MSB:`ASIRQ_HDR_ADDR_LSB])
						`ASIRQ_OFS_DEVICE_CONTROL: begin
							// Reload pulse passes the lock, the rest does not
							addr_reload = wdata[`ASIRQ_CTRL_ADDR_RELOAD_BIT];
							if (!lock_r) begin
								crc_en_nxt = wdata[`ASIRQ_CTRL_CRC_EN_BIT];
								pin_mode_nxt = wdata[`ASIRQ_CTRL_PIN_MODE_BIT];
								soft_rst = wdata[`ASIRQ_CTRL_SOFT_RESET_BIT];
							end
						end
						`ASIRQ_OFS_INTERRUPT_ENABLE_BITS: begin
							if (!lock_r) begin
								mask_nxt = wdata;
							end
						end
						`ASIRQ_OFS_LATCHED_EVENT_FLAGS: begin
							w1c = wdata;
						end
						`ASIRQ_OFS_CONFIG_WRITE_GUARD: begin
							if (wdata == `ASIRQ_LOCK_KEY) begin
								lock_nxt = 1'b1;
								xfer_nxt = 1'b1;
							end else if (wdata == `ASIRQ_UNLOCK_KEY) begin
								lock_nxt = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ASIRQ_RDATA, ASIRQ_CRC: begin
				// Change on fall, host samples on rise, MSB first
				if (fall) begin
					miso_nxt = tx_r[15];
					tx_nxt = {tx_r[14:0], 1'b0};
				end
				if (rise) begin
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == 5'(`ASIRQ_WORD_BITS - 1)) begin
						cnt_nxt = '0;
						if (st_r == ASIRQ_RDATA && crc_en_r) begin
							st_nxt = ASIRQ_CRC;
							tx_nxt = crc_val;
						end else begin
							st_nxt = ASIRQ_DONE;
						end
					end
				end
			end
			ASIRQ_DONE: begin
			end
		endcase
		// Chip select high ends or aborts any transfer
		if (cs_n_s && st_r != ASIRQ_IDLE) begin
			st_nxt = ASIRQ_IDLE;
		end
	end

	// Latched flags: hardware set wins over a same-cycle clear
	always_comb begin
		set_ev = live_cond;
		set_ev[`ASIRQ_FLAG_THERMAL_BIT] = tsd_r;
		set_ev[`ASIRQ_FLAG_RESET_BIT] = reset_done;
		flags_nxt = (flags_r & ~w1c) | set_ev;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= ASIRQ_IDLE;
			sclk_d_r <= 1'b0;
			cnt_r <= '0;
			rx_r <= '0;
			tx_r <= '0;
			hdr_r <= '0;
			miso_r <= 1'b0;
			crc_en_r <= 1'b0;
			pin_mode_r <= 1'b0;
			mask_r <= `ASIRQ_MASK_RESET;
			flags_r <= '0;
			lock_r <= 1'b0;
			xfer_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sclk_d_r <= sclk_s;
			cnt_r <= cnt_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			hdr_r <= hdr_nxt;
			miso_r <= miso_nxt;
			crc_en_r <= crc_en_nxt;
			pin_mode_r <= pin_mode_nxt;
			mask_r <= mask_nxt;
			flags_r <= flags_nxt;
			lock_r <= lock_nxt;
			xfer_r <= xfer_nxt;
		end
	end

	// MISO driven only while a word or its CRC goes out
	assign miso_o = miso_r;
	assign miso_oe = (st_r == ASIRQ_RDATA) || (st_r == ASIRQ_CRC);
	assign config_transfer = xfer_r;

	// ----------------------------------------
	// Shared pin: data push-pull or open-drain request
	// ----------------------------------------
	logic irq_active;
	logic [15:0] eff_mask;

	// Reset-complete always passes the mask
	always_comb begin
		eff_mask = mask_r;
		eff_mask[`ASIRQ_FLAG_RESET_BIT] = 1'b1;
	end
	assign irq_active = |(flags_r & eff_mask);

	// Busy forces data mode so a soft reset never leaves a stuck request
	always_comb begin
		if (pin_mode_r && !busy_r) begin
			shared_pin_o = 1'b0;
			shared_pin_oe = irq_active;
		end else begin
			shared_pin_o = channel_two_filtered_output;
			shared_pin_oe = 1'b1;
		end
	end

endmodule : asirq_top

`default_nettype wire

/* asirq_consts.svh */
/*
 Constants of the addressed SPI slave with interrupt and write lock:
 register offsets, field positions, reset values, keys and timing counts.
 Assumes inclusion by bare name from the package and the bench.
*/
// Operation
// - Overtemperature cuts load current; hysteresis re-enables
// - Control bit 2 selects data or interrupt pin
// - Interrupt mode open-drain, data mode push-pull
// - Sixteen-bit mask enables each interrupt source except reset-complete
// - Enabled latched flag holds request pin low
// - Writing ones clears latched flags, zeros keep
// - Power-up reset masks all except unmaskable reset-complete
// - Pin is data during reset; reset-complete set after
// - Live flags follow conditions; bit 14 busy
// - Sixteen-bit SPI slave, clock up to 10 MHz
// - Chip select high aborts, MISO released
// - Shift on falling edge, sample rising, MSB first
// - Strapped 3-bit chip address in header bits 2:0
// - Write header: address 14:4, bit 3 clear
// - Header bit 15 makes write broadcast
// - Read header bit 3 set; data next fall
// - Control bit 0 appends CRC after read data
// - CRC polynomial x16+x12+x5+1, seed all ones
// - Sixteen LFSR steps, final state sent out
// - Lock key sets lock, unlock key clears it
// - Locked still accepts lock, flags, address reload
`ifndef ASIRQ_CONSTS_SVH
`define ASIRQ_CONSTS_SVH

// ----------------------------------------
// Register offsets (11-bit header field)
// ----------------------------------------
`define ASIRQ_OFS_DEVICE_CONTROL 11'h001
`define ASIRQ_OFS_INTERRUPT_ENABLE_BITS 11'h002
`define ASIRQ_OFS_LATCHED_EVENT_FLAGS 11'h003
`define ASIRQ_OFS_LIVE_CONDITION_FLAGS 11'h004
`define ASIRQ_OFS_CONFIG_WRITE_GUARD 11'h005

// ----------------------------------------
// Header fields
// ----------------------------------------
`define ASIRQ_HDR_BCAST_BIT 15
`define ASIRQ_HDR_ADDR_MSB 14
`define ASIRQ_HDR_ADDR_LSB 4
`define ASIRQ_HDR_READ_BIT 3
`define ASIRQ_HDR_CHIP_MSB 2
`define ASIRQ_HDR_CHIP_LSB 0

// ----------------------------------------
// Control and flag fields
// ----------------------------------------
`define ASIRQ_CTRL_CRC_EN_BIT 0
`define ASIRQ_CTRL_PIN_MODE_BIT 2
`define ASIRQ_CTRL_ADDR_RELOAD_BIT 3
`define ASIRQ_CTRL_SOFT_RESET_BIT 4
`define ASIRQ_FLAG_RESET_BIT 14
`define ASIRQ_FLAG_THERMAL_BIT 12
`define ASIRQ_LOCK_STATE_BIT 0

// ----------------------------------------
// Reset values, keys, timing
// ----------------------------------------
`define ASIRQ_CTRL_RESET 16'h0000
`define ASIRQ_MASK_RESET 16'h0000
`define ASIRQ_LOCK_KEY 16'hade1
`define ASIRQ_UNLOCK_KEY 16'hade0
`define ASIRQ_CRC_SEED 16'hffff
`define ASIRQ_WORD_BITS 16
`define ASIRQ_CLK_PERIOD_NS 10
`define ASIRQ_RST_BUSY_NS 2000
`define ASIRQ_RST_BUSY_CYC (`ASIRQ_RST_BUSY_NS / `ASIRQ_CLK_PERIOD_NS)

`endif

/* asirq_pkg.sv */
/*
 Types of the addressed SPI slave block.
 Assumes the constants header sits in the include path.
*/
`include "asirq_consts.svh"

package asirq_pkg;

	// SPI engine states, one-hot
	typedef enum logic [5:0] {
		ASIRQ_IDLE = 6'b000001,
		ASIRQ_HDR = 6'b000010,
		ASIRQ_WDATA = 6'b000100,
		ASIRQ_RDATA = 6'b001000,
		ASIRQ_CRC = 6'b010000,
		ASIRQ_DONE = 6'b100000
	} asirq_state_t;

	typedef logic [15:0] asirq_word_t;
	typedef logic [10:0] asirq_addr_t;

endpackage : asirq_pkg

/* asirq_sync.sv */
/*
 Two-flop synchroniser for a bundle of independent levels.
 Assumes each bit is a slow level or is sampled well above its own rate.
*/
`timescale 1ns/1ps
`default_nettype none

module asirq_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// First stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;

endmodule : asirq_sync

`default_nettype wire

/* asirq_crc.sv */
/*
 CRC-16 over one register word, captured into a register on load.
 Assumes load is a one-cycle strobe on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module asirq_crc
	import asirq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic load,
	input wire asirq_pkg::asirq_word_t data,
	output asirq_pkg::asirq_word_t crc
);
	import asirq_pkg::*;

	asirq_word_t crc_r;
	asirq_word_t crc_nxt;

	// Sixteen LFSR steps, register MSB first (high byte, then low byte)
	function automatic asirq_word_t crc_word(input asirq_word_t d);
		asirq_word_t s;
		logic fb;
		s = `ASIRQ_CRC_SEED;
		for (int i = 0; i < `ASIRQ_WORD_BITS; i++) begin
			fb = d[15 - i] ^ s[15];
			s = {s[14:0], fb};
			s[5] = s[5] ^ fb;
			s[12] = s[12] ^ fb;
		end
		return s;
	endfunction : crc_word

	// Next value held until a new read header lands
	always_comb begin
		crc_nxt = crc_r;
		if (load) begin
			crc_nxt = crc_word(data);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			crc_r <= `ASIRQ_CRC_SEED;
		end else begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;

endmodule : asirq_crc

`default_nettype wire

/* asirq_properties.sv */
/*
 Port checks of the addressed SPI slave top, bound below.
 Assumes one ref_clk domain, srst synchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none

module asirq_props
	import asirq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic [2:0] addr_strap,
	input wire logic temp_above_limit,
	input wire logic temp_below_release,
	input wire asirq_pkg::asirq_word_t live_cond,
	input wire logic channel_two_filtered_output,
	input wire logic shared_pin_o,
	input wire logic shared_pin_oe,
	input wire logic load_current_en,
	input wire logic config_transfer
);
	import asirq_pkg::*;
	// ------
	// Relations
	// ------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// Sync delay of the pins is about three cycles, so allow six
	a_abort_release: assert property (cs_n [*6] |-> !miso_oe)
		else $error("miso driven while deselected");
	a_oe_after_hdr: assert property ($rose(miso_oe) |-> !cs_n && sclk)
		else $error("miso enabled away from a header rise");
	a_shift_on_fall: assert property (
		miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk)
		else $error("miso changed while sclk high");
	a_pin_open_drain: assert property (shared_pin_o |-> shared_pin_oe)
		else $error("shared pin high while released");
	a_reset_data_mode: assert property (
		$fell(srst) |-> (shared_pin_oe && !miso_oe) [*8])
		else $error("pin not in data mode after reset");
	a_thermal_cut: assert property (
		temp_above_limit [*6] |-> !load_current_en)
		else $error("load current on while over limit");
	a_thermal_back: assert property (
		(temp_below_release && !temp_above_limit) [*6] |-> load_current_en)
		else $error("load current off after cooling");
	a_cfg_pulse: assert property (config_transfer |=> !config_transfer)
		else $error("config transfer longer than a cycle");
endmodule : asirq_props

bind asirq_top asirq_props u_props (
	.ref_clk(ref_clk),
	.srst(srst),
	.sclk(sclk),
	.cs_n(cs_n),
	.mosi(mosi),
	.miso_o(miso_o),
	.miso_oe(miso_oe),
	.addr_strap(addr_strap),
	.temp_above_limit(temp_above_limit),
	.temp_below_release(temp_below_release),
	.live_cond(live_cond),
	.channel_two_filtered_output(channel_two_filtered_output),
	.shared_pin_o(shared_pin_o),
	.shared_pin_oe(shared_pin_oe),
	.load_current_en(load_current_en),
	.config_transfer(config_transfer)
);
`default_nettype wire

/* asirq_host.sv */
/*
 SPI host model: 160 ns serial clock, idle low between frames.
 Assumes the caller enters xfer only when no frame runs.
*/
`timescale 1ns/1ps
`default_nettype none

module asirq_host (
	input wire logic ref_clk,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	// ------
	// Frame driver
	// ------
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// Released miso reads as the inverse of its last bit, never a guess
	task automatic xfer(input logic [47:0] tx, input int nb,
		output logic [31:0] rx, output logic oe_seen);
		logic b;
		rx = '0;
		oe_seen = 1'b0;
		b = 1'b0;
		@(negedge ref_clk);
		cs_n = 1'b0;
		#80;
		for (int i = 0; i < nb; i++) begin
			mosi = tx[47 - i];
			#80;
			sclk = 1'b1;
			b = miso_oe ? miso_o : ~b;
			oe_seen = oe_seen | miso_oe;
			if (i >= 16)
				rx = {rx[30:0], b};
			#80;
			sclk = 1'b0;
		end
		#80;
		cs_n = 1'b1;
		mosi = ~mosi;
		#160;
	endtask : xfer
endmodule : asirq_host
`default_nettype wire

/* test_addressed_spi_slave_irq_lock.sv */
/*
 Bench of the addressed SPI slave: registers, interrupt pin, CRC,
 lock and thermal cut. Assumes design, checker and host compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asirq_consts.svh"

module test_addressed_spi_slave_irq_lock;
	import asirq_pkg::*;
	localparam asirq_addr_t CTL = `ASIRQ_OFS_DEVICE_CONTROL;
	localparam asirq_addr_t MSK = `ASIRQ_OFS_INTERRUPT_ENABLE_BITS;
	localparam asirq_addr_t FLG = `ASIRQ_OFS_LATCHED_EVENT_FLAGS;
	localparam asirq_addr_t LIV = `ASIRQ_OFS_LIVE_CONDITION_FLAGS;
	localparam asirq_addr_t LCK = `ASIRQ_OFS_CONFIG_WRITE_GUARD;
	localparam logic [2:0] CHIP = 3'h2;
	logic ref_clk, srst, sclk, cs_n, mosi, miso_o, miso_oe, oe_seen;
	logic temp_above_limit, temp_below_release, ch2;
	logic shared_pin_o, shared_pin_oe, load_current_en, config_transfer;
	logic [2:0] addr_strap;
	asirq_word_t live_cond;
	logic [31:0] rx;
	int fails, total_checks, cfg_cnt;

	asirq_top DUT (.ref_clk(ref_clk), .srst(srst), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.addr_strap(addr_strap), .temp_above_limit(temp_above_limit),
		.temp_below_release(temp_below_release), .live_cond(live_cond),
		.channel_two_filtered_output(ch2), .shared_pin_o(shared_pin_o),
		.shared_pin_oe(shared_pin_oe), .load_current_en(load_current_en),
		.config_transfer(config_transfer));
	asirq_host host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));

	// ------
	// Clock, watchdog, pulse count
	// ------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		fails++;
		conclude();
	end
	always @(posedge ref_clk) begin
		if (config_transfer === 1'b1)
			cfg_cnt++;
	end

	// ------
	// Access tasks
	// ------
	task chk(input string nm, input asirq_word_t exp, input asirq_word_t got);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk
	function asirq_word_t hw(logic bc, asirq_addr_t a, logic [2:0] c);
		return {bc, a, 1'b0, c};
	endfunction : hw
	// Reference CRC: poly 1021, seed ffff, MSB first
	function asirq_word_t crc16(asirq_word_t d);
		asirq_word_t s;
		s = 16'hffff;
		for (int j = 15; j >= 0; j--)
			s = {s[14:0], 1'b0} ^ ((d[j] ^ s[15]) ? 16'h1021 : 16'h0000);
		return s;
	endfunction : crc16
	task wr(input asirq_word_t h, input asirq_word_t d);
		host.xfer({h, d, 16'h0000}, 32, rx, oe_seen);
	endtask : wr
	task rd(input string nm, input asirq_addr_t a, input asirq_word_t e,
		input logic c);
		host.xfer({1'b0, a, 1'b1, CHIP, 32'h0}, c ? 48 : 32, rx, oe_seen);
		chk(nm, e, c ? rx[31:16] : rx[15:0]);
		if (c)
			chk("crc", crc16(e), rx[15:0]);
	endtask : rd
	task conclude();
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	// ------
	// Sequence
	// ------
	initial begin
		srst = 1'b1;
		addr_strap = CHIP;
		temp_above_limit = 1'b0;
		temp_below_release = 1'b1;
		live_cond = 16'h0000;
		ch2 = 1'b0;
		tick(20);
		srst = 1'b0;
		tick(4);
		chk("pin", 0, shared_pin_o);
		ch2 = 1'b1;
		tick(4);
		chk("pin", 1, shared_pin_o);
		chk("pin_oe", 1, shared_pin_oe);
		tick(`ASIRQ_RST_BUSY_CYC);
		rd("flags", FLG, 16'h4000, 0);
		rd("mask", MSK, 16'h0000, 0);
		rd("live", LIV, 16'h0000, 0);
		wr(hw(0, CTL, CHIP), 16'h0004);
		rd("ctrl", CTL, 16'h0004, 0);
		chk("irq", 0, shared_pin_o);
		chk("irq_oe", 1, shared_pin_oe);
		wr(hw(0, FLG, CHIP), 16'hbfff);
		chk("irq_oe", 1, shared_pin_oe);
		wr(hw(0, FLG, CHIP), 16'h4000);
		chk("irq_oe", 0, shared_pin_oe);
		live_cond = 16'h0002;
		tick(4);
		rd("live", LIV, 16'h0002, 0);
		live_cond = 16'h0000;
		rd("live", LIV, 16'h0000, 0);
		rd("flags", FLG, 16'h0002, 0);
		chk("masked", 0, shared_pin_oe);
		wr(hw(0, MSK, CHIP), 16'h0002);
		chk("unmasked", 1, shared_pin_oe);
		wr(hw(0, FLG, CHIP), 16'h0002);
		chk("cleared", 0, shared_pin_oe);
		wr(hw(0, CTL, CHIP), 16'h0005);
		rd("mask", MSK, 16'h0002, 1);
		wr(hw(0, LCK, CHIP), 16'hade1);
		chk("cfg_xfer", 1, cfg_cnt);
		wr(hw(0, CTL, CHIP), 16'h0000);
		wr(hw(0, MSK, CHIP), 16'h0000);
		wr(hw(0, LCK, CHIP), 16'h1234);
		rd("ctrl", CTL, 16'h0005, 1);
		rd("mask", MSK, 16'h0002, 1);
		rd("lock", LCK, 16'h0001, 1);
		// Address reload still passes the lock; old chip then gets no answer
		addr_strap = 3'h6;
		wr(hw(0, CTL, CHIP), 16'h0008);
		host.xfer({1'b0, LCK, 1'b1, CHIP, 32'h0}, 32, rx, oe_seen);
		chk("reload_oe", 0, oe_seen);
		addr_strap = CHIP;
		wr(hw(0, CTL, 3'h6), 16'h0008);
		live_cond = 16'h0008;
		tick(4);
		live_cond = 16'h0000;
		wr(hw(0, FLG, CHIP), 16'h0008);
		rd("flags", FLG, 16'h0000, 1);
		wr(hw(0, LCK, CHIP), 16'hade0);
		rd("lock", LCK, 16'h0000, 1);
		wr(hw(1, MSK, 3'h5), 16'h0003);
		rd("mask", MSK, 16'h0003, 1);
		wr(hw(0, MSK, 3'h5), 16'h0000);
		rd("mask", MSK, 16'h0003, 1);
		host.xfer({hw(0, MSK, 3'h5) | 16'h0008, 32'h0}, 32, rx, oe_seen);
		chk("foreign_oe", 0, oe_seen);
		host.xfer({1'b0, CTL, 1'b1, CHIP, 32'h0}, 20, rx, oe_seen);
		chk("abort_oe", 0, miso_oe);
		rd("ctrl", CTL, 16'h0005, 1);
		// Soft reset: pin back to data mode while busy, flag set after
		wr(hw(0, CTL, CHIP), 16'h0015);
		tick(4);
		chk("busy_pin", 1, shared_pin_o);
		chk("busy_oe", 1, shared_pin_oe);
		tick(`ASIRQ_RST_BUSY_CYC);
		rd("flags", FLG, 16'h4000, 1);
		chk("done_irq", 1, shared_pin_oe);
		wr(hw(0, FLG, CHIP), 16'h4000);
		chk("done_clr", 0, shared_pin_oe);
		temp_above_limit = 1'b1;
		temp_below_release = 1'b0;
		tick(8);
		chk("load_en", 0, load_current_en);
		rd("live", LIV, 16'h1000, 1);
		temp_above_limit = 1'b0;
		tick(8);
		chk("hyst", 0, load_current_en);
		temp_below_release = 1'b1;
		tick(8);
		chk("load_en", 1, load_current_en);
		rd("flags", FLG, 16'h1000, 1);
		conclude();
	end
endmodule : test_addressed_spi_slave_irq_lock
`default_nettype wire
